/* dv/scs_partner.sv */
// behavioural far-side serial device, slave or master as needed
`timescale 1ns/1ps
module scs_partner (
  input  wire logic mclk,
  input  wire logic cpol,
  input  wire logic cpha,
  input  wire logic dev_mst,
  input  wire logic sclk_w,
  input  wire logic mosi_w,
  input  wire logic miso_w,
  output logic      sclk,
  output logic      mosi,
  output logic      ss_n,
  output logic      miso
);
  logic [7:0] sb = 8'h00;
  logic [7:0] rb = 8'h00;
  logic       o = 1'b0;
  logic       prev = 1'b0;
  logic       junk = 1'b0;

  // outputs at rest: select high, clock still
  initial begin
    sclk = 1'b0;
    mosi = 1'b0;
    ss_n = 1'b1;
  end

  // released line toggles so a stale bit never passes for data
  always @(posedge mclk) junk <= ~junk;
  assign miso = !dev_mst ? junk : (cpha ? o : sb[7]);

  // slave role: shift on the change edge, capture on the other
  always @(posedge mclk) begin
    prev <= sclk_w;
    if (dev_mst && prev != sclk_w) begin
      if ((sclk_w == cpol) ^ cpha) begin
        o  <= sb[7];
        sb <= {sb[6:0], 1'b0};
      end else begin
        rb <= {rb[6:0], mosi_w};
      end
    end
  end

  // master role: 400 ns clock, select held low over the frame
  task automatic send(input logic [7:0] b);
    int k;
    #13 sclk = cpol;
    #200 ss_n = 1'b0;
    #600;
    for (k = 7; k >= 0; k--) begin
      if (!cpha) mosi = b[k];
      #200 sclk = ~cpol;
      if (cpha) mosi = b[k];
      else rb = {rb[6:0], miso_w};
      #200 sclk = cpol;
      if (cpha) rb = {rb[6:0], miso_w};
    end
    #300 mosi = ~mosi;
    ss_n = 1'b1;
  endtask
endmodule

/* dv/scs_top_tb.sv */
// self-checking bench for the serial port block
`timescale 1ns/1ps
module scs_top_tb;
  logic       mclk = 1'b0;
  logic       arst_n = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic       sfr_wr = 1'b0;
  logic       sfr_rd = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] tx_data = 8'h00;
  logic       tx_valid = 1'b0;
  logic       rx_ready = 1'b0;
  logic       rd_seen = 1'b0;
  logic       cpol = 1'b0;
  logic       cpha = 1'b0;
  logic       mst = 1'b0;
  logic [1:0] rdy_mode = 2'd0;
  logic [7:0] sfr_rdata, rx_data, t, m;
  logic       tx_ready, rx_valid, sclk_out, sclk_oe, mosi_out, mosi_oe;
  logic       miso_out, miso_oe, p_sclk, p_mosi, p_ss_n, p_miso;
  logic       sclk_w, mosi_w, miso_w;
  logic [7:0] rq_e[$], rq_m[$], xq[$];
  int         seed = 81;
  int         n_mismatch = 0;
  int         cmp_count = 0;
  int         i;

  always #25 mclk = ~mclk;

  // wire level from the block's enables; the partner drives when they are low
  assign sclk_w = sclk_oe ? sclk_out : p_sclk;
  assign mosi_w = mosi_oe ? mosi_out : p_mosi;
  assign miso_w = miso_oe ? miso_out : p_miso;

  scs_top dut (.mclk(mclk), .arst_n(arst_n), .ce(1'b1),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sclk_in(sclk_w),
    .sclk_out(sclk_out), .sclk_oe(sclk_oe), .mosi_in(mosi_w),
    .mosi_out(mosi_out), .mosi_oe(mosi_oe), .miso_in(miso_w),
    .miso_out(miso_out), .miso_oe(miso_oe), .slave_select_n(p_ss_n),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready));

  scs_partner p (.mclk(mclk), .cpol(cpol), .cpha(cpha), .dev_mst(mst),
    .sclk_w(sclk_w), .mosi_w(mosi_w), .miso_w(miso_w), .sclk(p_sclk),
    .mosi(p_mosi), .ss_n(p_ss_n), .miso(p_miso));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t ns: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    sfr_addr  <= a;
    sfr_wdata <= d;
    sfr_wr    <= 1'b1;
    @(posedge mclk);
    sfr_wr <= 1'b0;
  endtask

  // read with expectation noted for the monitor; msk hides don't-cares
  task automatic rd(input logic [7:0] a, input logic [7:0] e,
                    input logic [7:0] msk);
    @(posedge mclk);
    sfr_addr <= a;
    sfr_rd   <= 1'b1;
    rq_e.push_back(e & msk);
    rq_m.push_back(msk);
    @(posedge mclk);
    sfr_rd <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic push(input logic [7:0] b);
    @(posedge mclk);
    tx_data  <= b;
    tx_valid <= 1'b1;
    do @(posedge mclk); while (tx_ready !== 1'b1);
    tx_valid <= 1'b0;
  endtask

  task automatic setmode(input logic ms, input logic ph, input logic po);
    mst  <= ms;
    cpha <= ph;
    cpol <= po;
    wr(8'hA1, {1'b0, ms, ph, po, 4'h0});
    repeat (6) @(posedge mclk);
  endtask

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // results compared as they appear, oldest note first
  always @(posedge mclk) begin
    rd_seen  <= sfr_rd;
    rx_ready <= rdy_mode == 2'd2 || (rdy_mode == 2'd1 && ($random(seed) & 1));
    if (rd_seen) check(sfr_rdata & rq_m.pop_front(), rq_e.pop_front());
    if (rx_valid === 1'b1 && rx_ready) check(rx_data, xq.pop_front());
  end

  // hang guard, far beyond the expected run length
  initial begin
    #200000;
    n_mismatch++;
    wrap_up();
  end

  initial begin
    repeat (12) @(posedge mclk);
    arst_n <= 1'b1;
    rd(8'hA1, 8'h07, 8'hFF);
    rd(8'hA2, 8'h00, 8'hFF);
    wr(8'hA2, 8'hFF);
    wr(8'hA1, 8'hFF);
    rd(8'hA1, 8'h77, 8'hFF);
    $display("test registers done");
    // master: every polarity and phase, receiver stalling at random
    rdy_mode <= 2'd1;
    for (i = 0; i < 4; i++) begin
      setmode(1'b1, i[1], i[0]);
      t = $random(seed);
      m = $random(seed);
      p.sb <= m;
      xq.push_back(m);
      push(t);
      repeat (8) @(posedge mclk);
      rd(8'hA1, {2'b11, i[1], i[0], 4'h7}, 8'hFF);
      repeat (40) @(posedge mclk);
      check({7'h00, sclk_w}, {7'h00, cpol});
      check(p.rb, t);
      rd(8'hA1, {2'b01, i[1], i[0], 4'h7}, 8'hFF);
    end
    rdy_mode <= 2'd2;
    repeat (20) @(posedge mclk);
    $display("test master done");
    // slave: two frames fill the receive buffer, then it drains
    for (i = 0; i < 4; i++) begin
      rdy_mode <= 2'd0;
      setmode(1'b0, i[1], i[0]);
      t = $random(seed);
      m = $random(seed);
      xq.push_back(m);
      push(t);
      fork
        p.send(m);
        begin
          repeat (40) @(posedge mclk);
          rd(8'hA1, {2'b10, i[1], i[0], 4'h8}, 8'hFE);
        end
      join
      repeat (10) @(posedge mclk);
      check(p.rb, t);
      rd(8'hA1, {2'b00, i[1], i[0], 4'h6}, 8'hFF);
      if (i[0]) begin
        rdy_mode <= 2'd2;
        repeat (6) @(posedge mclk);
        rd(8'hA1, {2'b00, i[1], i[0], 4'h7}, 8'hFF);
      end
    end
    $display("test slave done");
    wrap_up();
  end
endmodule

/* hdl/scs_defines.svh */
// register map, field positions and timing counts of the serial port block
`ifndef SCS_DEFINES_SVH
`define SCS_DEFINES_SVH
`define SCS_CFG_ADDR    8'hA1
`define SCS_CFG_RST     8'h07
`define SCS_BIT_BUSY    7
`define SCS_BIT_MST     6
`define SCS_BIT_CPHA    5
`define SCS_BIT_CPOL    4
`define SCS_BIT_SEL     3
`define SCS_BIT_PIN     2
`define SCS_BIT_SHIFT_REGISTER_EMPTY    1
`define SCS_BIT_RXE     0
`define SCS_MCLK_NS     50
`define SCS_SCK_HALF_NS 100
`define SCS_HALF        (3'((`SCS_SCK_HALF_NS) / (`SCS_MCLK_NS)))
`define SCS_BIT_LEN     (3'(2 * `SCS_HALF))
`define SCS_BIT_LAST    (`SCS_BIT_LEN - 3'd1)
`define SCS_BYTE_LAST   3'd7
`define SCS_DGL_LAST    2'd2
`endif

/* hdl/scs_pkg.sv */
// types shared by the serial port block
package scs_pkg;
  typedef enum logic [1:0] {
    SCS_IDLE = 2'b01,
    SCS_XFER = 2'b10
  } scs_state_t;

  typedef struct packed {
    scs_state_t  st;
    logic        mst;
    logic        cpha;
    logic        cpol;
    logic        busy;
    logic        shift_register_empty;
    logic        fin;
    logic [2:0]  cnt;
    logic [2:0]  bits;
    logic [7:0]  shreg;
    logic [7:0]  txb;
    logic        txv;
    logic        txrdy;
    logic [7:0]  hd;
    logic        hv;
    logic [7:0]  tl;
    logic        tv;
    logic [7:0]  rxb;
    logic        pend;
    logic [1:0]  dgl;
    logic        nss_f;
    logic        sclk_d;
    logic        sclk_o;
    logic        mosi_o;
    logic        miso_o;
    logic        sclk_oe;
    logic        mosi_oe;
    logic        miso_oe;
    logic [7:0]  rdata;
  } scs_regs_t;

  typedef struct packed {
    logic [3:0] s1;
    logic [3:0] s2;
  } scs_sync_t;
endpackage

/* hdl/scs_sync.sv */
// two-stage synchroniser for the pin inputs
`timescale 1ns/1ps
module scs_sync
  import scs_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       arst_n,
  input  wire logic       ce,
  input  wire logic [3:0] din,
  output logic      [3:0] dout
);
  scs_sync_t r;
  scs_sync_t n;

  // first stage feeds only the second stage
  always_comb begin
    n = r;
    if (ce) begin
      n.s1 = din;
      n.s2 = r.s1;
    end
  end

  // pins idle high after reset
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      r <= '{s1: 4'hF, s2: 4'hF};
    end else begin
      r <= n;
    end
  end

  assign dout = r.s2;
endmodule

/* hdl/scs_top.sv */
// serial port configuration, status and shift engine
//
// Function
// - busy bit is 1 over a master transfer, and in slave from first clock edge to last sample; phase 0 slave also from final edge to deselect
// - master-select 0 means slave; 1 means master driving serial clock
// - phase 0 centres data on first clock edge; 1 on second edge
// - polarity 0 rests clock low when idle; 1 rests it high
// - selected bit follows the deglitched select input, low gives 1
// - select-pin bit returns raw pin level sampled at the read
// - slave: shift-empty set when byte done, nothing pending either way
// - shift-empty cleared on load from transmit buffer or clock edge
// - shift-empty reads 1 in master operation
// - slave: receive-empty is 0 while unread data waits, else 1
// - receive-empty reads 1 in master operation
// - slave samples incoming data at the middle of each bit
// - master samples incoming data one clock before each bit ends
`timescale 1ns/1ps
`include "scs_defines.svh"
module scs_top
  import scs_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       arst_n,
  input  wire logic       ce,
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] sfr_rdata,
  input  wire logic       sclk_in,
  output logic            sclk_out,
  output logic            sclk_oe,
  input  wire logic       mosi_in,
  output logic            mosi_out,
  output logic            mosi_oe,
  input  wire logic       miso_in,
  output logic            miso_out,
  output logic            miso_oe,
  input  wire logic       slave_select_n,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  output logic      [7:0] rx_data,
  output logic            rx_valid,
  input  wire logic       rx_ready
);
  scs_regs_t  r;
  scs_regs_t  n;
  logic [3:0] pins_s;
  logic       sclk_s;
  logic       mosi_s;
  logic       miso_s;
  logic       nss_s;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  scs_sync u_sync (
    .mclk   (mclk),
    .arst_n (arst_n),
    .ce     (ce),
    .din    ({sclk_in, mosi_in, miso_in, slave_select_n}),
    .dout   (pins_s)
  );
  assign sclk_s = pins_s[3];
  assign mosi_s = pins_s[2];
  assign miso_s = pins_s[1];
  assign nss_s  = pins_s[0];

  // ----------------------------------------------------------------
  // status word as software sees it
  // ----------------------------------------------------------------
  function automatic logic [7:0] cfg_word(input scs_regs_t q,
                                          input logic      pin);
    logic [7:0] w;
    w = 8'h00;
    w[`SCS_BIT_BUSY] = q.busy;
    w[`SCS_BIT_MST]  = q.mst;
    w[`SCS_BIT_CPHA] = q.cpha;
    w[`SCS_BIT_CPOL] = q.cpol;
    w[`SCS_BIT_SEL]  = ~q.nss_f;
    w[`SCS_BIT_PIN]  = pin;
    w[`SCS_BIT_SHIFT_REGISTER_EMPTY] = q.mst | q.shift_register_empty;
    w[`SCS_BIT_RXE]  = q.mst | ~q.hv;
    return w;
  endfunction

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  logic       sel;
  logic       rise;
  logic       fall;
  logic       lead;
  logic       trail;
  logic       push;
  logic [7:0] pb;
  logic [7:0] sh;

  always_comb begin
    n     = r;
    push  = 1'b0;
    pb    = r.rxb;
    sh    = r.shreg;
    rise  = sclk_s & ~r.sclk_d;
    fall  = ~sclk_s & r.sclk_d;
    lead  = r.cpol ? fall : rise;
    trail = r.cpol ? rise : fall;
    sel   = ~r.nss_f & ~r.mst;
    n.sclk_d = sclk_s;

    // select deglitch: three equal samples before the level moves
    if (nss_s == r.nss_f) begin
      n.dgl = 2'd0;
    end else if (r.dgl == `SCS_DGL_LAST) begin
      n.nss_f = nss_s;
      n.dgl   = 2'd0;
    end else begin
      n.dgl = r.dgl + 2'd1;
    end

    // register port: only the three control bits are writable
    if (sfr_wr && sfr_addr == `SCS_CFG_ADDR) begin
      n.mst  = sfr_wdata[`SCS_BIT_MST];
      n.cpha = sfr_wdata[`SCS_BIT_CPHA];
      n.cpol = sfr_wdata[`SCS_BIT_CPOL];
    end
    if (sfr_rd) begin
      n.rdata = (sfr_addr == `SCS_CFG_ADDR) ? cfg_word(r, nss_s) : 8'h00;
    end

    // transmit holding byte
    if (tx_valid && !r.txv) begin
      n.txb = tx_data;
      n.txv = 1'b1;
    end

    // receive buffer pop; head always holds the older byte
    if (rx_ready && r.hv) begin
      n.hd = r.tl;
      n.hv = r.tv;
      n.tv = 1'b0;
    end
    if (r.pend) begin
      push   = 1'b1;
      n.pend = 1'b0;
    end

    if (r.mst) begin
      // master: clock generated here, starts only when a byte is queued
      case (r.st)
        SCS_IDLE: begin
          n.sclk_o = r.cpol;
          if (r.txv && !r.pend) begin
            n.shreg  = r.txb;
            n.txv    = 1'b0;
            n.busy   = 1'b1;
            n.st     = SCS_XFER;
            n.cnt    = 3'd0;
            n.bits   = 3'd0;
            n.mosi_o = r.txb[7];
            n.sclk_o = r.cpol ^ r.cpha;
          end
        end
        SCS_XFER: begin
          n.cnt = r.cnt + 3'd1;
          if (r.cnt == `SCS_BIT_LAST) begin
            // late sample leaves the slave the longest settle time
            sh      = {r.shreg[6:0], miso_s};
            n.shreg = sh;
            n.cnt   = 3'd0;
            n.bits  = r.bits + 3'd1;
            n.mosi_o = sh[7];
            if (r.bits == `SCS_BYTE_LAST) begin
              push   = 1'b1;
              pb     = sh;
              n.busy = 1'b0;
              n.st   = SCS_IDLE;
            end
          end
          if (n.st == SCS_XFER) begin
            // phase 0 idles first half, phase 1 idles second half
            n.sclk_o = r.cpol ^ (r.cpha ? (n.cnt < `SCS_HALF)
                                        : (n.cnt >= `SCS_HALF));
          end else begin
            n.sclk_o = r.cpol;
          end
        end
        default: begin
          n.st   = SCS_IDLE;
          n.busy = 1'b0;
        end
      endcase
      n.shift_register_empty = 1'b1;
      n.fin  = 1'b0;
    end else if (!sel) begin
      // slave not selected: drop any partial byte
      n.st     = SCS_IDLE;
      n.busy   = 1'b0;
      n.bits   = 3'd0;
      n.sclk_o = r.cpol;
      if (r.st == SCS_XFER) begin
        n.fin = 1'b1;
      end
    end else begin
      // slave selected: preload a byte while the shift register is empty
      if (r.st == SCS_IDLE && r.shift_register_empty && r.txv) begin
        n.shreg  = r.txb;
        n.txv    = 1'b0;
        n.shift_register_empty   = 1'b0;
        n.fin    = 1'b0;
        n.miso_o = r.txb[7];
      end
      if (rise || fall) begin
        n.shift_register_empty = 1'b0;
        n.fin  = 1'b0;
        n.busy = 1'b1;
        n.st   = SCS_XFER;
      end
      if (r.cpha ? lead : trail) begin
        n.miso_o = r.shreg[7];
      end
      if (r.cpha ? trail : lead) begin
        // the sampling edge sits at the middle of the bit
        sh      = {r.shreg[6:0], mosi_s};
        n.shreg = sh;
        n.bits  = r.bits + 3'd1;
        if (r.bits == `SCS_BYTE_LAST) begin
          push   = 1'b1;
          pb     = sh;
          n.bits = 3'd0;
          n.busy = 1'b0;
          n.st   = SCS_IDLE;
          n.fin  = 1'b1;
        end
      end
    end

    // store into the buffer; a full buffer parks the byte in pend
    if (push) begin
      if (!n.hv) begin
        n.hd = pb;
        n.hv = 1'b1;
      end else if (!n.tv) begin
        n.tl = pb;
        n.tv = 1'b1;
      end else begin
        n.rxb  = pb;
        n.pend = 1'b1;
      end
    end

    // empty only once nothing waits on either side
    if (!r.mst && n.fin && !n.txv && !n.pend) begin
      n.shift_register_empty = 1'b1;
    end

    n.txrdy   = ~n.txv;
    n.sclk_oe = n.mst;
    n.mosi_oe = n.mst;
    n.miso_oe = ~n.mst & ~n.nss_f;

    // a low enable freezes everything
    if (!ce) begin
      n = r;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      r        <= '0;
      r.st     <= SCS_IDLE;
      r.shift_register_empty   <= 1'(`SCS_CFG_RST >> `SCS_BIT_SHIFT_REGISTER_EMPTY);
      r.nss_f  <= 1'b1;
      r.sclk_d <= 1'b1;
      r.txrdy  <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign sfr_rdata = r.rdata;
  assign sclk_out  = r.sclk_o;
  assign sclk_oe   = r.sclk_oe;
  assign mosi_out  = r.mosi_o;
  assign mosi_oe   = r.mosi_oe;
  assign miso_out  = r.miso_o;
  assign miso_oe   = r.miso_oe;
  assign tx_ready  = r.txrdy;
  assign rx_data   = r.hd;
  assign rx_valid  = r.hv;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  logic rd_cfg;
  assign rd_cfg = ce && sfr_rd && sfr_addr == `SCS_CFG_ADDR;

  sequence s_mst_start;
    ce && r.mst && r.st == SCS_IDLE && n.st == SCS_XFER;
  endsequence
  sequence s_busy_hold;
    r.busy [*8];
  endsequence
  property p_busy_master;
    s_mst_start |=> s_busy_hold;
  endproperty
  a_busy_master: assert property (p_busy_master)
    else $error("busy dropped during master transfer");

  property p_slave_no_clk;
    (ce && !r.mst && !sfr_wr) |=> !sclk_oe;
  endproperty
  a_slave_no_clk: assert property (p_slave_no_clk)
    else $error("clock driven in slave operation");

  property p_phase_half;
    (r.mst && r.st == SCS_XFER && !r.cpha && r.cnt < `SCS_HALF)
      |-> sclk_out == r.cpol;
  endproperty
  a_phase_half: assert property (p_phase_half)
    else $error("phase 0 clock left idle level early");

  property p_idle_pol;
    (r.mst && r.st == SCS_IDLE && $stable(r.cpol) && $stable(r.st))
      |-> sclk_out == r.cpol;
  endproperty
  a_idle_pol: assert property (p_idle_pol)
    else $error("idle clock level differs from polarity");

  property p_sel_read;
    rd_cfg |=> sfr_rdata[`SCS_BIT_SEL] == $past(~r.nss_f);
  endproperty
  a_sel_read: assert property (p_sel_read)
    else $error("selected bit not the deglitched select");

  property p_pin_read;
    rd_cfg |=> sfr_rdata[`SCS_BIT_PIN] == $past(nss_s);
  endproperty
  a_pin_read: assert property (p_pin_read)
    else $error("pin bit not the raw select level");

  property p_mst_flags;
    (rd_cfg && r.mst) |=> sfr_rdata[1:0] == 2'b11;
  endproperty
  a_mst_flags: assert property (p_mst_flags)
    else $error("master empty flags not 1");

  property p_shift_register_empty_edge;
    // the edge that completes a byte may set it again at once
    (ce && sel && (rise || fall) && !n.fin) |=> !r.shift_register_empty;
  endproperty
  a_shift_register_empty_edge: assert property (p_shift_register_empty_edge)
    else $error("shift-empty not cleared on clock edge");

  property p_rxe_slave;
    (rd_cfg && !r.mst && r.hv) |=> !sfr_rdata[`SCS_BIT_RXE];
  endproperty
  a_rxe_slave: assert property (p_rxe_slave)
    else $error("receive-empty set with unread data");

  property p_mst_sample;
    (ce && r.mst && r.st == SCS_XFER && r.cnt == `SCS_BIT_LAST)
      |=> r.shreg[0] == $past(miso_s);
  endproperty
  a_mst_sample: assert property (p_mst_sample)
    else $error("master sample not taken at last cycle of bit");
endmodule
